// file: mbfs_pkg.sv
/*
 * constants, register map and states of the multiplex bus frame scheduler.
 * assumes a 20 MHz system clock and a 32-bit APB register port.
 */
// Function
// - at or below 100 kHz every frame ends with an eight-period pulseless gap
// - above 100 kHz the end-of-frame gap lasts sixteen periods
// - a frame holds mode times frame length pulses, mode 1 or 2
// - frame length lies between 16 and 256 addresses
// - bus clock rate stays between 10 kHz and 200 kHz
// - scanned channel count lies between 1 and 16
// - with settings fixed every frame lasts the same time
// - without priority each scanned channel is visited once per cycle
// - a priority channel is selected in every second frame
// - other channels rotate through the frames between priority frames
// - master/slave mode may post each input bit on receipt
// - deferred posting waits until the end of the gap after the frame
// - host path delay stays under 32 bus periods with immediate master/slave posting; other posting waits for the end of the gap
// - debounce needs 2 or 3 identical consecutive samples
// - a debounced signal is never tied to a multiplex channel
// - the active channel number 0 to 15 is broadcast before each frame
// - master/slave addresses take two pulses, input then output
package mbfs_pkg;
    // timing
    localparam int CLK_HZ = 20_000_000;
    localparam int BUS_MIN_HZ = 10_000;
    localparam int BUS_MAX_HZ = 200_000;
    localparam int FAST_HZ = 100_000;
    localparam int HALF_MIN = (CLK_HZ + 2 * BUS_MAX_HZ - 1) / (2 * BUS_MAX_HZ);
    localparam int HALF_MAX = CLK_HZ / (2 * BUS_MIN_HZ);
    localparam int HALF_FAST = CLK_HZ / (2 * FAST_HZ);
    localparam int SYNC_SLOW = 8;
    localparam int SYNC_FAST = 16;
    localparam int HIP_PERIODS = 32;
    localparam int BCAST_BITS = 4;
    // ranges
    localparam int FLEN_MIN = 16;
    localparam int FLEN_MAX = 256;
    localparam int NCH_MIN = 1;
    localparam int NCH_MAX = 16;
    localparam int DEB_W = 16;
    // register offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_FLEN = 8'h04;
    localparam logic [7:0] A_CDIV = 8'h08;
    localparam logic [7:0] A_NCH = 8'h0c;
    localparam logic [7:0] A_STAT = 8'h10;
    localparam logic [7:0] A_DEB = 8'h14;
    localparam logic [7:0] A_IN = 8'h40;
    localparam logic [7:0] A_OUT = 8'h60;
    // field positions
    localparam int CTRL_EN = 0;
    localparam int CTRL_MS = 1;
    localparam int CTRL_DEFER = 2;
    localparam int CTRL_PRIO = 3;
    localparam int CTRL_PCH = 4;
    localparam int CTRL_DEB3 = 8;
    localparam int STAT_SYNC = 4;
    localparam int STAT_PRIO = 5;
    localparam int STAT_FRM = 16;
    // reset values
    localparam logic [8:0] FLEN_RST = 9'h010;
    localparam logic [9:0] CDIV_RST = 10'h064;
    localparam logic [4:0] NCH_RST = 5'h01;
    typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_SYNC} mbfs_st_t;
endpackage

// file: mbfs_debounce.sv
/*
 * per-bit digital debounce over successive frames.
 * assumes one strobe per frame end, on the same clock as the scheduler.
 */
`timescale 1ns/1ps
module mbfs_debounce #(
    parameter int W = 16
) (
    // system
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    // samples
    input wire logic strobe,
    input wire logic len3,
    input wire logic [W-1:0] sample,
    output logic [W-1:0] filt
);
    typedef struct packed {
        logic [W-1:0] h1;
        logic [W-1:0] h2;
        logic [W-1:0] filt;
    } mbfs_deb_t;

    mbfs_deb_t s;
    mbfs_deb_t n;
    logic [W-1:0] agree;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // a bit agrees when the last 2 or 3 samples match
    for (genvar gi = 0; gi < W; gi++) begin : g_bit
        assign agree[gi] = (sample[gi] == s.h1[gi]) &&
            (!len3 || sample[gi] == s.h2[gi]);
    end

    always_comb begin
        n = s;
        if (strobe) begin
            n.h2 = s.h1;
            n.h1 = sample;
            n.filt = (agree & sample) | (~agree & s.filt);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s <= '0;
        end else if (ce) begin
            s <= n;
        end
    end

    assign filt = s.filt;

    a_deb_two: assert property (
        (ce && strobe && !len3 && sample == s.h1) |=> filt == $past(sample))
        else $error("two matching samples not applied");
    a_deb_hold: assert property (
        (ce && strobe && len3 && sample != s.h2) |=>
        ((filt ^ $past(s.filt)) & $past(sample ^ s.h2)) == '0)
        else $error("three-sample debounce changed early");
endmodule // mbfs_debounce

// file: mbfs_top.sv
/*
 * clock source and host interface of a serial multiplexed control bus:
 * frame timing, sync gap, channel rotation, input posting, APB registers.
 * assumes a pulled-up data line resolved outside, an APB master on sys_clk.
 */
`timescale 1ns/1ps
module mbfs_top
    import mbfs_pkg::*;
(
    // system
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // bus link
    output logic bclk_o,
    input wire logic data_i,
    output logic data_o,
    output logic data_oe
);
    typedef struct packed {
        mbfs_st_t st;
        logic [31:0] prdata;
        logic pslverr;
        logic en;
        logic ms;
        logic defer;
        logic prio;
        logic deb3;
        logic [3:0] pch;
        logic [8:0] flen;
        logic [9:0] half;
        logic [4:0] nch;
        logic [15:0] deb_en;
        logic [8:0] f_flen;
        logic f_ms;
        logic [9:0] f_half;
        logic [4:0] f_gap;
        logic [10:0] div;
        logic hi;
        logic [9:0] pulse;
        logic [4:0] gap;
        logic [3:0] chan;
        logic [3:0] rr;
        logic was_prio;
        logic [15:0] frames;
        logic [255:0] img;
        logic [255:0] stage;
        logic [255:0] outimg;
        logic d_oe;
        logic [1:0] dsync;
        logic [19:0] fcyc;
        logic [15:0] scyc;
    } mbfs_state_t;

    mbfs_state_t s;
    mbfs_state_t n;
    logic sync_end;
    logic prio_ok;
    logic [9:0] tgt;
    logic [DEB_W-1:0] deb_filt;
    logic [255:0] in_view;

    function automatic logic [3:0] nxt_ch(input logic [3:0] c,
                                          input logic [4:0] cnt);
        logic [4:0] t;
        t = {1'b0, c} + 5'h01;
        return (t >= cnt) ? 4'h0 : t[3:0];
    endfunction

    function automatic logic [31:0] clampv(input logic [31:0] v,
                                           input logic [31:0] lo,
                                           input logic [31:0] hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic [32:0] reg_rd(input logic [7:0] a);
        logic [32:0] r;
        r = 33'h0;
        case (a)
            A_CTRL: begin
                r[CTRL_EN] = s.en;
                r[CTRL_MS] = s.ms;
                r[CTRL_DEFER] = s.defer;
                r[CTRL_PRIO] = s.prio;
                r[CTRL_PCH +: 4] = s.pch;
                r[CTRL_DEB3] = s.deb3;
            end
            A_FLEN: r[8:0] = s.flen;
            A_CDIV: r[9:0] = s.half;
            A_NCH: r[4:0] = s.nch;
            A_STAT: begin
                r[3:0] = s.chan;
                r[STAT_SYNC] = (s.st == ST_SYNC);
                r[STAT_PRIO] = s.was_prio;
                r[STAT_FRM +: 16] = s.frames;
            end
            A_DEB: r[15:0] = s.deb_en;
            default: begin
                if (a[7:5] == A_IN[7:5]) begin
                    r[31:0] = in_view[{a[4:2], 5'h00} +: 32];
                end else if (a[7:5] == A_OUT[7:5]) begin
                    r[31:0] = s.outimg[{a[4:2], 5'h00} +: 32];
                end else begin
                    r[32] = 1'b1;
                end
            end
        endcase
        return r;
    endfunction

    // debounced word bypasses channel selection entirely
    assign in_view = {s.img[255:DEB_W],
        (deb_filt & s.deb_en) | (s.img[DEB_W-1:0] & ~s.deb_en)};
    assign prio_ok = s.prio && s.nch >= 5'h02 && {1'b0, s.pch} < s.nch;
    assign tgt = s.f_ms ? {s.f_flen, 1'b0} : {1'b0, s.f_flen};

    always_comb begin
        logic [7:0] ad;
        logic [3:0] t;
        logic start;
        logic [1:0] bi;
        ad = 8'h00;
        t = 4'h0;
        start = 1'b0;
        bi = 2'h0;
        n = s;
        sync_end = 1'b0;
        n.dsync = {s.dsync[0], data_i};
        // register port
        if (psel && !penable) begin
            {n.pslverr, n.prdata} = reg_rd(paddr);
        end
        if (psel && penable && pwrite) begin
            case (paddr)
                A_CTRL: begin
                    n.en = pwdata[CTRL_EN];
                    n.ms = pwdata[CTRL_MS];
                    n.defer = pwdata[CTRL_DEFER];
                    n.prio = pwdata[CTRL_PRIO];
                    n.pch = pwdata[CTRL_PCH +: 4];
                    n.deb3 = pwdata[CTRL_DEB3];
                end
                A_FLEN: n.flen = 9'(clampv(pwdata, FLEN_MIN, FLEN_MAX));
                A_CDIV: n.half = 10'(clampv(pwdata, HALF_MIN, HALF_MAX));
                A_NCH: n.nch = 5'(clampv(pwdata, NCH_MIN, NCH_MAX));
                A_DEB: n.deb_en = pwdata[15:0];
                default: begin
                    if (paddr[7:5] == A_OUT[7:5]) begin
                        n.outimg[{paddr[4:2], 5'h00} +: 32] = pwdata;
                    end
                end
            endcase
        end
        // frame engine
        case (s.st)
            ST_IDLE: begin
                n.hi = 1'b1;
                start = s.en;
            end
            ST_FRAME: begin
                n.div = s.div + 11'h001;
                if (s.div == {1'b0, s.f_half} - 11'h001) begin
                    n.div = 11'h000;
                    if (!s.hi) begin
                        n.hi = 1'b1;
                    end else begin
                        ad = s.f_ms ? s.pulse[8:1] : s.pulse[7:0];
                        // first pulse of a pair carries input data
                        if (!s.f_ms || !s.pulse[0]) begin
                            n.stage[ad] = ~s.dsync[1];
                            // posted in the same cycle, far under 32 periods
                            if (s.f_ms && !s.defer) begin
                                n.img[ad] = ~s.dsync[1];
                            end
                        end
                        n.pulse = s.pulse + 10'h001;
                        if (n.pulse == tgt) begin
                            n.st = ST_SYNC;
                            n.gap = 5'h00;
                            if (!prio_ok) begin
                                n.chan = nxt_ch(s.chan, s.nch);
                                n.was_prio = 1'b0;
                            end else if (!s.was_prio) begin
                                n.chan = s.pch;
                                n.was_prio = 1'b1;
                            end else begin
                                t = nxt_ch(s.rr, s.nch);
                                if (t == s.pch) begin
                                    t = nxt_ch(t, s.nch);
                                end
                                n.chan = t;
                                n.rr = t;
                                n.was_prio = 1'b0;
                            end
                        end else begin
                            n.hi = 1'b0;
                        end
                    end
                end
            end
            ST_SYNC: begin
                // clock stays high for the whole gap
                n.div = s.div + 11'h001;
                if (s.div == {s.f_half, 1'b0} - 11'h001) begin
                    n.div = 11'h000;
                    n.gap = s.gap + 5'h01;
                    if (n.gap == s.f_gap) begin
                        sync_end = 1'b1;
                        n.frames = s.frames + 16'h0001;
                        if (s.defer || !s.f_ms) begin
                            n.img = s.stage;
                        end
                        start = s.en;
                        n.st = ST_IDLE;
                    end
                end
            end
            default: n.st = ST_IDLE;
        endcase
        // length, mode, divider and gap length are frozen for a whole frame
        if (start) begin
            n.st = ST_FRAME;
            n.f_flen = s.flen;
            n.f_ms = s.ms;
            n.f_half = s.half;
            n.f_gap = (s.half < 10'(HALF_FAST)) ? 5'(SYNC_FAST)
                : 5'(SYNC_SLOW);
            n.div = 11'h000;
            n.pulse = 10'h000;
            n.hi = 1'b0;
        end
        // data line: output pulses and channel broadcast
        n.d_oe = 1'b0;
        if (n.st == ST_FRAME && n.f_ms && n.pulse[0]) begin
            n.d_oe = n.outimg[n.pulse[8:1]];
        end
        if (n.st == ST_SYNC && n.gap >= n.f_gap - 5'(BCAST_BITS)) begin
            bi = 2'(n.gap - (n.f_gap - 5'(BCAST_BITS)));
            n.d_oe = n.chan[bi];
        end
        n.fcyc = (s.st == ST_FRAME) ? s.fcyc + 20'h00001 : 20'h00000;
        n.scyc = (s.st == ST_SYNC) ? s.scyc + 16'h0001 : 16'h0000;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s <= '0;
            s.flen <= FLEN_RST;
            s.half <= CDIV_RST;
            s.nch <= NCH_RST;
            s.hi <= 1'b1;
            s.dsync <= 2'h3;
        end else if (ce) begin
            s <= n;
        end
    end

    mbfs_debounce #(
        .W(DEB_W)
    ) u_deb (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ce(ce),
        .strobe(sync_end),
        .len3(s.deb3),
        .sample(s.stage[DEB_W-1:0]),
        .filt(deb_filt)
    );

    assign prdata = s.prdata;
    assign pready = 1'b1;
    assign pslverr = s.pslverr;
    assign bclk_o = s.hi;
    assign data_o = 1'b0;
    assign data_oe = s.d_oe;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_sync_in;
        s.st == ST_FRAME ##1 s.st == ST_SYNC;
    endsequence
    sequence s_sync_out;
        s.st == ST_SYNC ##1 s.st != ST_SYNC;
    endsequence

    a_gap_len: assert property (
        (ce && s.st == ST_SYNC && n.st != ST_SYNC) |->
        32'(s.scyc) + 1 == 32'(s.f_gap) * 2 * 32'(s.f_half))
        else $error("sync gap length wrong");
    a_gap_quiet: assert property (
        s.st == ST_SYNC |-> bclk_o)
        else $error("clock pulse inside sync gap");
    a_gap_choice: assert property (
        (s.st == ST_FRAME && $past(s.st) != ST_FRAME) |->
        s.f_gap == ((s.f_half < 10'(HALF_FAST)) ? 5'(SYNC_FAST)
        : 5'(SYNC_SLOW)))
        else $error("gap length does not follow rate");
    a_frame_pulses: assert property (
        (ce && s.st == ST_FRAME && n.st == ST_SYNC) |->
        s.pulse + 10'h001 == tgt)
        else $error("pulse count per frame wrong");
    a_frame_fixed: assert property (
        (ce && s.st == ST_FRAME && n.st == ST_SYNC) |->
        32'(s.fcyc) + 1 == 32'(tgt) * 2 * 32'(s.f_half))
        else $error("frame duration wrong");
    a_cfg_range: assert property (
        s.flen >= 9'(FLEN_MIN) && s.flen <= 9'(FLEN_MAX) &&
        s.half >= 10'(HALF_MIN) && s.half <= 10'(HALF_MAX) &&
        s.nch >= 5'(NCH_MIN) && s.nch <= 5'(NCH_MAX))
        else $error("configuration out of range");
    a_chan_step: assert property (
        s_sync_in ##0 (!prio_ok && $stable(s.nch)) |->
        s.chan == nxt_ch($past(s.chan), s.nch))
        else $error("channel did not advance by one");
    a_prio_turn: assert property (
        s_sync_in ##0 (prio_ok && !$past(s.was_prio)) |-> s.chan == s.pch)
        else $error("priority channel skipped");
    a_prio_other: assert property (
        s_sync_in ##0 (prio_ok && $past(s.was_prio)) |-> s.chan != s.pch)
        else $error("priority channel taken twice running");
    a_defer_post: assert property (
        s_sync_out ##0 $past(s.defer) |-> s.img == $past(s.stage))
        else $error("deferred data not posted at gap end");
    a_defer_hold: assert property (
        (s.st == ST_FRAME && $past(s.st) == ST_FRAME && s.defer &&
        $past(s.defer)) |-> $stable(s.img))
        else $error("deferred data posted inside frame");
endmodule // mbfs_top

// file: mbfs_bus_dev.sv
/* bus device model: one non-multiplexed I/O device on the clock and data
   lines, sending input bits and latching output bits.
   assumes an open-drain data line with its pull-up resolved outside. */
`timescale 1ns/1ps
module mbfs_bus_dev (
    // system
    input wire logic sys_clk,
    // bus link
    input wire logic bclk,
    input wire logic line,
    output logic pull,
    // setup
    input wire logic ms,
    input wire logic [9:0] half,
    input wire logic [15:0] in_bits,
    output logic [15:0] out_bits
);
    logic bq = 1'b1;
    logic [15:0] out_sh = '0;
    int run = 0;
    int cnt = 0;
    initial begin
        pull = 1'b0;
        out_bits = '0;
    end
    always @(posedge sys_clk) begin
        bq <= bclk;
        run <= bclk ? run + 1 : 0;
        // a pause longer than a pulse is the gap
        if (run == 2 * int'(half)) begin
            cnt <= 0;
            pull <= 1'b0;
            out_bits <= out_sh;
        end
        if (bq && !bclk) begin
            cnt <= cnt + 1;
            // logic 1 is sent by pulling the line low
            if (ms)
                pull <= !cnt[0] && cnt < 32 && in_bits[cnt / 2];
            else
                pull <= cnt < 16 && in_bits[cnt];
        end
        if (!bq && bclk && ms && !cnt[0] && cnt > 0 && cnt <= 32)
            out_sh[(cnt - 1) / 2] <= !line;
    end
endmodule // mbfs_bus_dev

// file: multiplex_bus_frame_scheduler_tb.sv
/* self-checking bench of the frame scheduler: apb tasks, frame monitor,
   one bus device model.
   assumes the designer's register map and a 20 MHz clock. */
`timescale 1ns/1ps
module multiplex_bus_frame_scheduler_tb;
    import mbfs_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rd_v;
    logic pready, pslverr, er_v, bclk_o, data_o, data_oe, pull;
    logic ms_m = 1'b0;
    logic [9:0] half_m = 10'h064;
    logic [15:0] in_m = '0;
    logic [15:0] out_m, pa, pb, po;
    logic bq = 1'b1;
    logic [3:0] bc = '0;
    logic [7:0] ca[6] = '{A_FLEN, A_FLEN, A_CDIV, A_CDIV, A_NCH, A_NCH};
    int cw[6] = '{300, 5, 10, 2000, 0, 20};
    int cx[6] = '{256, 16, 50, 1000, 1, 16};
    int bad_count = 0;
    int checks = 0;
    int hi = 0;
    int pc = 0;
    int per = 0;
    int q_pc[$], q_run[$], q_per[$];
    wire logic line = !pull && (data_oe ? data_o : 1'b1);

    always #25 sys_clk = ~sys_clk;

    mbfs_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bclk_o(bclk_o), .data_i(line),
        .data_o(data_o), .data_oe(data_oe));
    mbfs_bus_dev i_dev (.sys_clk(sys_clk), .bclk(bclk_o), .line(line),
        .pull(pull), .ms(ms_m), .half(half_m), .in_bits(in_m),
        .out_bits(out_m));

    // a fall after a long high run starts a frame
    always @(posedge sys_clk) begin
        bq <= bclk_o;
        hi <= bclk_o ? hi + 1 : 0;
        per <= per + 1;
        // mid-period sample of the channel bits at the end of the gap
        for (int k = 0; k < BCAST_BITS; k++)
            if (bclk_o && hi == 2 * int'(half_m) * (k + 1 - BCAST_BITS +
                    (half_m < 10'(HALF_FAST) ? SYNC_FAST : SYNC_SLOW)))
                bc[k] <= !line;
        if (bq && !bclk_o) begin
            pc <= pc + 1;
            if (hi > 2 * int'(half_m)) begin
                q_pc.push_back(pc);
                q_run.push_back(hi);
                q_per.push_back(per);
                pc <= 1;
                per <= 1;
            end
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd_v = prdata;
        er_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic gapw(logic lvl);
        int n = 0;
        do begin
            apb(1'b0, A_STAT, '0);
            n++;
        end while (rd_v[STAT_SYNC] !== lvl && n < 3000);
        if (rd_v[STAT_SYNC] !== lvl)
            bad_count++;
    endtask

    task automatic step();
        gapw(1'b0);
        gapw(1'b1);
    endtask

    task automatic hold(logic v, int f);
        in_m <= {15'h0000, v};
        repeat (f) step();
    endtask

    task automatic in_is(logic [15:0] e);
        apb(1'b0, A_IN, '0);
        chk("in_image", rd_v[15:0], e);
    endtask

    task automatic meas(int cd);
        int g;
        g = cd < HALF_FAST ? SYNC_FAST : SYNC_SLOW;
        half_m <= 10'(cd);
        apb(1'b1, A_CDIV, 32'(cd));
        apb(1'b1, A_CTRL, 32'h1);
        q_pc.delete();
        q_run.delete();
        q_per.delete();
        for (int n = 0; n < 20000 && q_pc.size() < 2; n++)
            @(posedge sys_clk);
        chk("pulses", q_pc[1], 16);
        chk("gap_run", q_run[1], cd * (2 * g + 1));
        chk("period", q_per[1], (16 + g) * 2 * cd);
    endtask

    task automatic chan(int n, int pe, int p);
        int obs[5];
        int e;
        int lnp;
        lnp = -1;
        apb(1'b1, A_NCH, 32'(n));
        apb(1'b1, A_CTRL, 32'(1 | pe << CTRL_PRIO | p << CTRL_PCH));
        for (int i = 0; i < 5; i++) begin
            step();
            obs[i] = int'(rd_v[3:0]);
            if (i > 0)
                chk("broadcast", 32'(bc), 32'(obs[i-1]));
        end
        for (int i = 1; i < 5; i++) begin
            if (pe == 0)
                e = (obs[i-1] + 1) % n;
            else if (obs[i-1] != p) begin
                e = p;
                lnp = obs[i-1];
            end else begin
                e = (lnp + 1) % n;
                if (e == p)
                    e = (e + 1) % n;
            end
            if (i > 1 && (pe == 0 || obs[i-1] != p || lnp >= 0))
                chk("channel", obs[i], e);
        end
    endtask

    initial begin
        void'($urandom(35485));
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        apb(1'b0, A_CTRL, '0);
        chk("ctrl_rst", rd_v, 32'h0);
        apb(1'b0, A_FLEN, '0);
        chk("flen_rst", rd_v, 32'h10);
        apb(1'b0, A_CDIV, '0);
        chk("cdiv_rst", rd_v, 32'h64);
        apb(1'b0, A_NCH, '0);
        chk("nch_rst", rd_v, 32'h1);
        apb(1'b0, 8'h30, '0);
        chk("unmapped_err", 32'(er_v), 32'h1);
        chk("unmapped_rd", rd_v, 32'h0);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, ca[i], 32'(cw[i]));
            apb(1'b0, ca[i], '0);
            chk("clamp", rd_v, 32'(cx[i]));
        end
        apb(1'b1, A_FLEN, 32'h10);
        apb(1'b1, A_NCH, 32'h1);
        meas(50);
        meas(100);
        // master/slave posting, deferred then immediate
        half_m <= 10'h032;
        ms_m <= 1'b1;
        apb(1'b1, A_CDIV, 32'h32);
        step();
        apb(1'b1, A_CTRL, 32'h7);
        pa = 16'($urandom);
        in_m <= pa;
        step();
        pb = 16'($urandom);
        in_m <= pb;
        step();
        in_is(pa);
        gapw(1'b0);
        in_is(pb);
        chk("ms_pulses", q_pc[$], 32);
        apb(1'b1, A_CTRL, 32'h3);
        step();
        pa = 16'($urandom);
        in_m <= pa;
        po = 16'($urandom);
        apb(1'b1, A_OUT, {16'h0000, po});
        step();
        in_is(pa);
        gapw(1'b0);
        chk("out_bits", out_m, po);
        ms_m <= 1'b0;
        chan(3, 0, 0);
        chan(4, 1, 2);
        // address 0 is debounced and on no multiplex channel
        apb(1'b1, A_DEB, 32'h1);
        apb(1'b1, A_CTRL, 32'h101);
        hold(1'b0, 3);
        hold(1'b1, 2);
        in_m <= '0;
        gapw(1'b0);
        in_is(16'h0000);
        gapw(1'b1);
        hold(1'b1, 3);
        gapw(1'b0);
        in_is(16'h0001);
        apb(1'b1, A_CTRL, 32'h1);
        gapw(1'b1);
        in_m <= '0;
        step();
        gapw(1'b0);
        in_is(16'h0001);
        step();
        gapw(1'b0);
        in_is(16'h0000);
        tally_and_finish();
    end

    initial begin
        repeat (200000) @(posedge sys_clk);
        bad_count++;
        tally_and_finish();
    end
endmodule // multiplex_bus_frame_scheduler_tb
